//--- rtl/page_ext_consts.vh
// constants for the data page address extension block
`ifndef PAGE_EXT_CONSTS_VH
`define PAGE_EXT_CONSTS_VH

`define PG_W            10
`define EA_W            16
`define EA_TOP          15
`define PG_ZERO         10'h000
`define PG_ONE          10'h001
`define PG_EDS_LAST     10'h1FF
`define PG_PSV_FIRST    10'h200
`define PG_PSV_LSW_LAST 10'h2FF
`define PG_PSV_MSB_1ST  10'h300
`define PG_PSV_LAST     10'h3FF
`define PG_RESET        10'h001
`define PG_PSV_BIT      9

// addressing mode codes
`define MODE_W          3
`define MODE_DIRECT     3'h0
`define MODE_PRE_MOD    3'h1
`define MODE_POST_MOD   3'h2
`define MODE_REG_OFFSET 3'h3
`define MODE_MODULO     3'h4
`define MODE_BIT_REV    3'h5

// page step outcomes
`define STEP_W          2
`define STEP_NONE       2'h0
`define STEP_INC        2'h1
`define STEP_DEC        2'h2

`endif

//--- rtl/page_boundary_check.v
// boundary outcome decoder for one page-crossing access
`timescale 1ns/1ps
`default_nettype none
`include "page_ext_consts.vh"

module page_boundary_check (
	input  wire [`PG_W-1:0]   i_page,
	input  wire               i_is_write,
	input  wire [`MODE_W-1:0] i_mode,
	input  wire               i_base_ea15,
	input  wire               i_overflow,
	input  wire               i_underflow,
	output reg  [`STEP_W-1:0] o_step,
	output reg                o_ea15
);

	reg linear_mode;
	reg paged_start;

	always @* begin
		linear_mode = (i_mode == `MODE_PRE_MOD) || (i_mode == `MODE_POST_MOD);
		paged_start = i_base_ea15;
		o_step      = `STEP_NONE;
		o_ea15      = i_base_ea15;
		// crossings only count when the unmodified address was in a page
		if (paged_start && (i_overflow || i_underflow)) begin
			if (!linear_mode) begin
				o_ea15 = 1'b1;
			end else if (i_overflow) begin
				if ((i_page == `PG_EDS_LAST) || (!i_is_write && i_page == `PG_PSV_LAST)) begin
					o_ea15 = 1'b0;
				end else begin
					o_step = `STEP_INC;
					o_ea15 = 1'b1;
				end
			end else begin
				if (!i_is_write && ((i_page == `PG_ONE) || (i_page == `PG_PSV_FIRST))) begin
					o_ea15 = 1'b0;
				end else begin
					o_step = `STEP_DEC;
					o_ea15 = 1'b1;
				end
			end
		end
	end

endmodule
`default_nettype wire

//--- rtl/data_page_address_extension.v
// paged data space address extension for a 16-bit core
`timescale 1ns/1ps
`default_nettype none
`include "page_ext_consts.vh"

module data_page_address_extension (
	input  wire                    i_sys_clk,
	input  wire                    i_srst,
	input  wire                    i_req,
	input  wire                    i_is_write,
	input  wire [`MODE_W-1:0]      i_mode,
	input  wire [`EA_W-1:0]        i_base_ea,
	input  wire [`EA_W-1:0]        i_mod_ea,
	input  wire                    i_carry_out,
	input  wire                    i_borrow_out,
	input  wire                    i_page_wr,
	input  wire                    i_page_wr_sel,
	input  wire [`PG_W-1:0]        i_page_wr_data,
	output reg                     o_valid,
	output reg                     o_paged,
	output reg  [`PG_W-1:0]        o_page,
	output reg  [`EA_W-1:0]        o_effective_address,
	output reg                     o_addr_error_trap,
	output reg  [`PG_W-1:0]        o_read_page_select,
	output reg  [`PG_W-1:0]        o_write_page_select
);

	// ==========================================================
	// page registers
	reg  [`PG_W-1:0]   read_page_select_reg;
	reg  [`PG_W-1:0]   write_page_select_reg;
	reg  [`PG_W-1:0]   read_page_select_next;
	reg  [`PG_W-1:0]   write_page_select_next;
	reg  [`PG_W-1:0]   active_page_select;
	reg  [`PG_W-1:0]   stepped_page;
	reg  [`EA_W-1:0]   raw_ea;
	reg  [`EA_W-1:0]   final_ea;
	reg                overflow;
	reg                underflow;
	reg                trap;
	wire [`STEP_W-1:0] step;
	wire               ea15;
	// per-access decode
	reg                window_exit;
	reg                crossing;
	reg                paged_final;
	reg                zero_page_hit;
	reg                ps_write_hit;
	reg                accept;
	reg                reject;
	reg                step_read;
	reg                step_write;
	reg                load_read;
	reg                load_write;

	// ==========================================================
	// active page selection
	always @* begin
		// reads and writes keep separate pages, so one move can span two pages
		active_page_select = read_page_select_reg;
		if (i_is_write) begin
			active_page_select = write_page_select_reg;
		end
	end

	// ==========================================================
	// window exit
	// a crossing out of the upper window shows as bit 15 dropping together with a carry
	// or borrow past it; large offsets can skip whole pages, which is accepted and not
	// corrected, so a linear page space holds only for small steps
	always @* begin
		window_exit = i_base_ea[`EA_TOP] && !i_mod_ea[`EA_TOP];
		overflow    = window_exit && i_carry_out;
		underflow   = window_exit && i_borrow_out;
		crossing    = overflow || underflow;
		raw_ea      = i_mod_ea;
		if (crossing) begin
			raw_ea[`EA_TOP] = 1'b0;
		end
	end

	page_boundary_check u_check (
		.i_page      (active_page_select),
		.i_is_write  (i_is_write),
		.i_mode      (i_mode),
		.i_base_ea15 (i_base_ea[`EA_TOP]),
		.i_overflow  (overflow),
		.i_underflow (underflow),
		.o_step      (step),
		.o_ea15      (ea15)
	);

	// ==========================================================
	// page stepping
	always @* begin
		case (step)
			`STEP_INC: begin
				stepped_page = active_page_select + `PG_ONE;
			end
			`STEP_DEC: begin
				stepped_page = active_page_select - `PG_ONE;
			end
			default: begin
				// wrapping modes and edge pages leave the page where it is
				stepped_page = active_page_select;
			end
		endcase
	end

	// ==========================================================
	// final address bit 15
	always @* begin
		final_ea = raw_ea;
		if (crossing) begin
			// the boundary decoder chooses between staying paged and base data space
			final_ea[`EA_TOP] = ea15;
		end else begin
			final_ea[`EA_TOP] = i_mod_ea[`EA_TOP];
		end
		paged_final = final_ea[`EA_TOP];
	end

	// ==========================================================
	// address-error traps
	// traps look at the page before any step, so a refused access never moves it
	always @* begin
		zero_page_hit = 1'b0;
		ps_write_hit  = 1'b0;
		if (paged_final) begin
			if (active_page_select == `PG_ZERO) begin
				zero_page_hit = 1'b1;
			end
			if (i_is_write && active_page_select[`PG_PSV_BIT]) begin
				ps_write_hit = 1'b1;
			end
		end
		trap   = zero_page_hit || ps_write_hit;
		accept = i_req && !trap;
		reject = i_req && trap;
	end

	// ==========================================================
	// page register next values
	always @* begin
		step_read  = accept && !i_is_write;
		step_write = accept && i_is_write;
		load_read  = i_page_wr && !i_page_wr_sel;
		load_write = i_page_wr && i_page_wr_sel;
		read_page_select_next  = read_page_select_reg;
		write_page_select_next = write_page_select_reg;
		// software loads take priority over a stepping access in the same cycle
		if (load_read) begin
			read_page_select_next = i_page_wr_data;
		end else if (step_read) begin
			read_page_select_next = stepped_page;
		end
		if (load_write) begin
			write_page_select_next = i_page_wr_data;
		end else if (step_write) begin
			write_page_select_next = stepped_page;
		end
	end

	// ==========================================================
	// page registers
	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			read_page_select_reg  <= `PG_RESET;
			write_page_select_reg <= `PG_RESET;
		end else begin
			read_page_select_reg  <= read_page_select_next;
			write_page_select_reg <= write_page_select_next;
		end
	end

	// ==========================================================
	// answer outputs
	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_valid             <= 1'b0;
			o_addr_error_trap   <= 1'b0;
			o_effective_address <= {`EA_W{1'b0}};
		end else begin
			// exactly one of the two pulses answers each request
			o_valid             <= accept;
			o_addr_error_trap   <= reject;
			o_effective_address <= final_ea;
		end
	end

	// ==========================================================
	// page outputs
	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_paged             <= 1'b0;
			o_page              <= `PG_ZERO;
			o_read_page_select  <= `PG_RESET;
			o_write_page_select <= `PG_RESET;
		end else begin
			// copies track the next value so they line up with the registers
			o_read_page_select  <= read_page_select_next;
			o_write_page_select <= write_page_select_next;
			o_paged             <= paged_final;
			if (paged_final) begin
				o_page <= stepped_page;
			end else begin
				// bit 15 low means base data space, page ignored
				o_page <= `PG_ZERO;
			end
		end
	end

endmodule
`default_nettype wire

//--- sim/dpae_sva.sv
// port assertions for the data page address extension block
`timescale 1ns/1ps
`default_nettype none
`include "page_ext_consts.vh"
module dpae_sva (
	input wire logic i_sys_clk,
	input wire logic i_srst,
	input wire logic i_req,
	input wire logic i_is_write,
	input wire logic [`MODE_W-1:0] i_mode,
	input wire logic [`EA_W-1:0] i_base_ea,
	input wire logic [`EA_W-1:0] i_mod_ea,
	input wire logic i_carry_out,
	input wire logic i_page_wr,
	input wire logic o_valid,
	input wire logic o_paged,
	input wire logic [`PG_W-1:0] o_page,
	input wire logic [`EA_W-1:0] o_effective_address,
	input wire logic o_addr_error_trap,
	input wire logic [`PG_W-1:0] o_read_page_select,
	input wire logic [`PG_W-1:0] o_write_page_select
);
// ====
// a software page load in the same cycle wins, so those cycles are left out
wire go = i_req && !i_page_wr;
// a direct access with bit 15 set stays paged, so the page register alone decides a trap
wire dir = i_mode == `MODE_DIRECT && i_mod_ea[15];
wire lin = i_mode == `MODE_PRE_MOD || i_mode == `MODE_POST_MOD;
wire [`PG_W-1:0] act = i_is_write ? o_write_page_select : o_read_page_select;
default clocking @(posedge i_sys_clk); endclocking
default disable iff (i_srst);
answer_once_a: assert property (i_req |=> o_valid ^ o_addr_error_trap)
	else $error("answer");
idle_quiet_a: assert property (!i_req |=> !(o_valid | o_addr_error_trap))
	else $error("idle");
zero_trap_a: assert property (go && !i_is_write && dir && o_read_page_select == `PG_ZERO
	|=> o_addr_error_trap) else $error("zero page");
ps_write_a: assert property (go && i_is_write && dir && o_write_page_select[`PG_PSV_BIT]
	|=> o_addr_error_trap) else $error("ps write");
base_page_a: assert property (go && !i_base_ea[15] && !i_mod_ea[15]
	|=> o_valid && !o_paged && o_page == `PG_ZERO) else $error("base page");
ea_top_a: assert property (go && lin && i_carry_out && i_base_ea[15] && !i_mod_ea[15]
	&& act == `PG_EDS_LAST |=> o_valid && !o_effective_address[`EA_TOP]) else $error("ea top");
ovf_step_a: assert property (go && !i_is_write && i_mode == `MODE_POST_MOD && i_carry_out
	&& i_base_ea[15] && !i_mod_ea[15] && o_read_page_select == `PG_PSV_LSW_LAST
	|=> o_read_page_select == `PG_PSV_MSB_1ST && o_effective_address[15]) else $error("ovf");
offset_keep_a: assert property (go && i_mode == `MODE_REG_OFFSET
	|=> $stable(o_read_page_select) && $stable(o_write_page_select)) else $error("offset");
cover property (o_addr_error_trap);
cover property (o_valid && !o_paged);
cover property (o_valid && o_paged);
endmodule
bind data_page_address_extension dpae_sva u_sva (.i_sys_clk, .i_srst, .i_req, .i_is_write,
	.i_mode, .i_base_ea, .i_mod_ea, .i_carry_out, .i_page_wr, .o_valid, .o_paged, .o_page,
	.o_effective_address, .o_addr_error_trap, .o_read_page_select, .o_write_page_select);
`default_nettype wire

//--- sim/agu_model.sv
// address generation unit stand-in issuing accesses and page loads
`timescale 1ns/1ps
`default_nettype none
module agu_model (
	input wire logic i_sys_clk,
	output logic o_req,
	output logic o_is_write,
	output logic [2:0] o_mode,
	output logic [15:0] o_base_ea,
	output logic [15:0] o_mod_ea,
	output logic o_carry_out,
	output logic o_borrow_out,
	output logic o_page_wr,
	output logic o_page_wr_sel,
	output logic [9:0] o_page_wr_data
);
// ====
initial {o_req, o_is_write, o_mode, o_base_ea, o_mod_ea, o_carry_out, o_borrow_out,
	o_page_wr, o_page_wr_sel, o_page_wr_data} = '0;
// steps stay small, so page crossing stays linear
task automatic issue(input logic w, input logic [2:0] m, input logic [15:0] b, d,
		input logic c, r);
	@(negedge i_sys_clk);
	{o_req, o_is_write, o_mode, o_base_ea, o_mod_ea, o_carry_out, o_borrow_out} =
		{1'b1, w, m, b, d, c, r};
	@(negedge i_sys_clk);
	o_req = 1'b0;
	// a released address bus does not hold its last value
	o_base_ea = ~o_base_ea;
	o_mod_ea = ~o_mod_ea;
endtask
task automatic load(input logic s, input logic [9:0] v);
	@(negedge i_sys_clk);
	{o_page_wr, o_page_wr_sel, o_page_wr_data} = {1'b1, s, v};
	@(negedge i_sys_clk);
	o_page_wr = 1'b0;
endtask
endmodule
`default_nettype wire

//--- sim/tb_data_page_address_extension.sv
// self-checking bench for the data page address extension block
`timescale 1ns/1ps
`default_nettype none
`include "page_ext_consts.vh"
module tb_data_page_address_extension;
logic clk = 1'b0;
logic srst = 1'b1;
logic req, wr, cy, bw, pw, ps, valid, paged, trap;
logic [2:0] mode;
logic [15:0] base, moda, ea;
logic [9:0] pwd, page, rps, wps;
int miscompares = 0;
int checks_done = 0;
initial forever #20 clk = ~clk;
agu_model u_agu (.i_sys_clk(clk), .o_req(req), .o_is_write(wr), .o_mode(mode),
	.o_base_ea(base), .o_mod_ea(moda), .o_carry_out(cy), .o_borrow_out(bw),
	.o_page_wr(pw), .o_page_wr_sel(ps), .o_page_wr_data(pwd));
data_page_address_extension u_dut (.i_sys_clk(clk), .i_srst(srst), .i_req(req),
	.i_is_write(wr), .i_mode(mode), .i_base_ea(base), .i_mod_ea(moda), .i_carry_out(cy),
	.i_borrow_out(bw), .i_page_wr(pw), .i_page_wr_sel(ps), .i_page_wr_data(pwd),
	.o_valid(valid), .o_paged(paged), .o_page(page), .o_effective_address(ea),
	.o_addr_error_trap(trap), .o_read_page_select(rps), .o_write_page_select(wps));
// ====
task automatic wrap_up;
	$display("checks %0d mismatches %0d", checks_done, miscompares);
	if (miscompares == 0 && checks_done > 0)
		$display("== PASSED ==");
	else
		$display("== FAILED ==");
	$finish;
endtask
task automatic chk(input string n, input logic [31:0] e, g);
	checks_done++;
	if (g !== e) begin
		miscompares++;
		$display("MISMATCH %s expected %h seen %h", n, e, g);
	end
endtask
// expected word is {valid, trap, paged, page, address}
task automatic acc(input logic w, input logic [2:0] m, input logic [15:0] b, d,
		input logic c, r, input logic [28:0] e);
	u_agu.issue(w, m, b, d, c, r);
	chk("resp", {3'b0, e}, {3'b0, valid, trap, paged, page, ea});
endtask
task automatic t_step;
	chk("reset pages", {12'h0, 10'h001, 10'h001}, {12'h0, rps, wps});
	u_agu.load(0, 10'h2FF);
	acc(0, `MODE_POST_MOD, 16'hFFFE, 16'h0000, 1, 0, {3'b101, 10'h300, 16'h8000});
	acc(0, `MODE_PRE_MOD, 16'h8000, 16'h7FFE, 0, 1, {3'b101, 10'h2FF, 16'hFFFE});
	u_agu.load(1, 10'h0FE);
	acc(1, `MODE_POST_MOD, 16'hFFFE, 16'h0000, 1, 0, {3'b101, 10'h0FF, 16'h8000});
	chk("stepped pages", {12'h0, 10'h2FF, 10'h0FF}, {12'h0, rps, wps});
	$display("page step test done");
endtask
task automatic t_edge;
	u_agu.load(0, 10'h1FF);
	acc(0, `MODE_POST_MOD, 16'hFFFE, 16'h0000, 1, 0, {3'b100, 10'h0, 16'h0000});
	u_agu.load(0, 10'h3FF);
	acc(0, `MODE_PRE_MOD, 16'hFFFE, 16'h0000, 1, 0, {3'b100, 10'h0, 16'h0000});
	u_agu.load(1, 10'h1FF);
	u_agu.load(0, 10'h200);
	acc(1, `MODE_POST_MOD, 16'hFFFE, 16'h0000, 1, 0, {3'b100, 10'h0, 16'h0000});
	acc(0, `MODE_PRE_MOD, 16'h8000, 16'h7FFE, 0, 1, {3'b100, 10'h0, 16'h7FFE});
	chk("kept pages", {12'h0, 10'h200, 10'h1FF}, {12'h0, rps, wps});
	u_agu.load(0, 10'h001);
	acc(0, `MODE_POST_MOD, 16'h8000, 16'h7FFE, 0, 1, {3'b100, 10'h0, 16'h7FFE});
	chk("kept first page", {22'h0, 10'h001}, {22'h0, rps});
	$display("edge page test done");
endtask
task automatic t_wrap;
	u_agu.load(0, 10'h150);
	for (int k = 3; k < 6; k++)
		acc(0, k[2:0], 16'hFFFE, 16'h0000, 1, 0, {3'b101, 10'h150, 16'h8000});
	acc(0, `MODE_DIRECT, 16'h1234, 16'h1234, 0, 0, {3'b100, 10'h0, 16'h1234});
	$display("wrap test done");
endtask
task automatic t_trap;
	u_agu.load(1, 10'h000);
	u_agu.issue(1, `MODE_DIRECT, 16'h8000, 16'h8000, 0, 0);
	chk("zero page trap", 2'b01, {valid, trap});
	u_agu.load(0, 10'h000);
	u_agu.issue(0, `MODE_DIRECT, 16'h8006, 16'h8006, 0, 0);
	chk("zero read trap", 2'b01, {valid, trap});
	u_agu.load(1, 10'h200);
	u_agu.issue(1, `MODE_DIRECT, 16'h8002, 16'h8002, 0, 0);
	chk("ps write trap", 2'b01, {valid, trap});
	u_agu.issue(1, `MODE_POST_MOD, 16'hFFFE, 16'h0000, 1, 0);
	chk("trap keeps page", {20'h0, 2'b01, 10'h200}, {20'h0, valid, trap, wps});
	u_agu.load(0, 10'h200);
	acc(0, `MODE_DIRECT, 16'h8004, 16'h8004, 0, 0, {3'b101, 10'h200, 16'h8004});
	$display("trap test done");
endtask
initial begin
	repeat (16) @(negedge clk);
	srst = 1'b0;
	t_step;
	t_edge;
	t_wrap;
	t_trap;
	wrap_up;
end
initial begin
	repeat (5000) @(posedge clk);
	miscompares++;
	wrap_up;
end
endmodule
`default_nettype wire
